//--- logic/usdp_params.svh
/*
 Constants for the UART shadow data port: register offsets, field layout,
 reset values and depths.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef USDP_PARAMS_SVH
`define USDP_PARAMS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define USDP_ALIAS_BASE 32'h5000_1030
`define USDP_ALIAS_TWO 32'h5000_1038
`define USDP_ALIAS_WORDS 16
`define USDP_CTRL_ADDR 32'h5000_1080
`define USDP_STAT_ADDR 32'h5000_1084
`define USDP_IRQ_STAT_ADDR 32'h5000_1088
`define USDP_IRQ_MASK_ADDR 32'h5000_108C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define USDP_DATA_MSB 7
`define USDP_CTRL_FIFO_EN 0
`define USDP_CTRL_IR_MODE 1
`define USDP_STAT_DR 0
`define USDP_STAT_HOLDING_EMPTY_FLAG 5
`define USDP_IRQ_RX_OVR 0
`define USDP_IRQ_TX_LOST 1
`define USDP_IRQ_RX_DATA 2

// ----------------------------------------
// Reset values and depths
// ----------------------------------------
`define USDP_DATA_RESET 16'h0000
`define USDP_REG_RESET 32'h0000_0000
`define USDP_FIFO_DEPTH 16
`define USDP_PTR_W 4
`define USDP_CNT_W 5

`endif

//--- logic/usdp_pkg.sv
/*
 Types shared by the UART shadow data port modules.
 Assumes usdp_params.svh is on the include path.
*/
`include "usdp_params.svh"

package usdp_pkg;
   typedef logic [7:0] usdp_byte_t;
   typedef logic [31:0] usdp_word_t;
   typedef logic [`USDP_PTR_W-1:0] usdp_ptr_t;
   typedef logic [`USDP_CNT_W-1:0] usdp_cnt_t;
   typedef logic [2:0] usdp_irq_t;
endpackage

//--- logic/usdp_fifo.sv
/*
 Sixteen-entry byte FIFO. A push when full is dropped and reported by
 full_out; a pop when empty is ignored.
 Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "usdp_params.svh"

module usdp_fifo
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // Control
   input wire logic flush_in,
   input wire logic push_in,
   input wire usdp_pkg::usdp_byte_t push_data_in,
   input wire logic pop_in,
   // Status and head
   output usdp_pkg::usdp_byte_t head_out,
   output logic empty_out,
   output logic full_out
);
   import usdp_pkg::*;

   typedef struct packed {
      usdp_ptr_t wr_ptr;
      usdp_ptr_t rd_ptr;
      usdp_cnt_t count;
   } usdp_fifo_state_t;

   usdp_fifo_state_t st_ff;
   usdp_fifo_state_t nxt_st;
   usdp_byte_t mem_ff [`USDP_FIFO_DEPTH];
   logic do_push;
   logic do_pop;

   assign empty_out = (st_ff.count == '0);
   assign full_out = (st_ff.count == usdp_cnt_t'(`USDP_FIFO_DEPTH));
   assign head_out = mem_ff[st_ff.rd_ptr];
   assign do_push = push_in && !full_out;
   assign do_pop = pop_in && !empty_out;

   always_comb
   begin
      nxt_st = st_ff;
      if (flush_in)
      begin
         nxt_st = '0;
      end
      else
      begin
         if (do_push)
         begin
            nxt_st.wr_ptr = st_ff.wr_ptr + usdp_ptr_t'(1);
         end
         if (do_pop)
         begin
            nxt_st.rd_ptr = st_ff.rd_ptr + usdp_ptr_t'(1);
         end
         nxt_st.count = st_ff.count + usdp_cnt_t'(do_push) - usdp_cnt_t'(do_pop);
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Storage has no reset; only the pointers matter
   always_ff @(posedge mclk_in)
   begin
      if (do_push && !flush_in)
      begin
         mem_ff[st_ff.wr_ptr] <= push_data_in;
      end
   end
endmodule // usdp_fifo

//--- logic/usdp_core.sv
/*
 UART shadow data port: sixteen aliased word locations of one data port,
 receive buffer or FIFO, transmit holding buffer or FIFO, status and
 interrupt registers.
 Assumes a serial engine outside that delivers received bytes as one-cycle
 strobes and takes transmit bytes by a valid/ready handshake.
*/
//------------------------------------------------------------
// Function
// - Sixteen consecutive word addresses all reach the same data port.
// - Read bits 7:0 give the byte received from serial or infrared input.
// - Read data is trustworthy only while data-ready is set.
// - FIFO off: new byte overwrites unread buffer and flags overrun.
// - FIFO on: data port read returns oldest receive FIFO entry.
// - Full receive FIFO keeps contents, drops new byte, flags overrun.
// - Written byte is queued for serial or inverted infrared output.
// - FIFO off: writing one character clears holding-empty.
// - FIFO off: further writes before holding-empty overwrite pending data.
// - FIFO on: up to sixteen writes accepted before transmit FIFO full.
// - Writes while transmit FIFO full are discarded, contents unchanged.
//------------------------------------------------------------
`timescale 1ns/10ps
`include "usdp_params.svh"

module usdp_core
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // Register port
   input wire usdp_pkg::usdp_word_t addr_in,
   input wire usdp_pkg::usdp_word_t wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output usdp_pkg::usdp_word_t rdata_out,
   // Receive side from the serial engine
   input wire logic rx_strobe_in,
   input wire usdp_pkg::usdp_byte_t rx_uart_data_in,
   input wire usdp_pkg::usdp_byte_t rx_ir_data_in,
   // Transmit side to the serial engine
   output logic tx_valid_out,
   input wire logic tx_ready_in,
   output usdp_pkg::usdp_byte_t tx_data_out,
   output logic tx_uart_sel_out,
   output logic tx_ir_sel_n_out,
   // Status and interrupt
   output logic data_ready_flag_out,
   output logic holding_empty_flag_out,
   output logic overrun_out,
   output logic irq_out
);
   import usdp_pkg::*;

   //------------------------------------------------------------
   // Address decode
   //------------------------------------------------------------
   function automatic logic is_alias(input usdp_word_t a);
      usdp_word_t lo;
      usdp_word_t hi;
      lo = `USDP_ALIAS_BASE;
      hi = `USDP_ALIAS_BASE + 32'(`USDP_ALIAS_WORDS * 4);
      is_alias = (a >= lo) && (a < hi) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic hit(input usdp_word_t a, input usdp_word_t r);
      hit = (a == r);
   endfunction

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic fifo_en;
      logic ir_mode;
      usdp_byte_t rx_buf;
      logic rx_full;
      usdp_byte_t tx_buf;
      logic tx_full;
      usdp_irq_t irq_stat;
      usdp_irq_t irq_mask;
      usdp_word_t rdata;
      logic overrun;
      usdp_byte_t tx_data;
   } usdp_core_state_t;

   usdp_core_state_t st_ff;
   usdp_core_state_t nxt_st;

   logic data_wr;
   logic data_rd;
   usdp_byte_t rx_byte;
   logic rxf_empty;
   logic rxf_full;
   usdp_byte_t rxf_head;
   logic txf_empty;
   logic txf_full;
   usdp_byte_t txf_head;
   logic rxf_push;
   logic rxf_pop;
   logic txf_push;
   logic txf_pop;
   logic flush;
   logic ctrl_wr;
   logic tx_take;
   logic rx_ovr_ev;
   logic tx_lost_ev;
   usdp_irq_t events;

   assign data_wr = wr_in && is_alias(addr_in);
   assign data_rd = rd_in && is_alias(addr_in);
   assign ctrl_wr = wr_in && hit(addr_in, `USDP_CTRL_ADDR);
   // FIFO-enable change flushes both FIFOs so stale entries never leak across
   assign flush = ctrl_wr && (wdata_in[`USDP_CTRL_FIFO_EN] != st_ff.fifo_en);

   assign rx_byte = st_ff.ir_mode ? rx_ir_data_in : rx_uart_data_in;

   //------------------------------------------------------------
   // FIFOs
   //------------------------------------------------------------
   assign rxf_push = st_ff.fifo_en && rx_strobe_in;
   assign rxf_pop = st_ff.fifo_en && data_rd;
   assign txf_push = st_ff.fifo_en && data_wr;
   assign txf_pop = st_ff.fifo_en && tx_ready_in;

   usdp_fifo u_rx_fifo
   (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .flush_in(flush),
      .push_in(rxf_push),
      .push_data_in(rx_byte),
      .pop_in(rxf_pop),
      .head_out(rxf_head),
      .empty_out(rxf_empty),
      .full_out(rxf_full)
   );

   usdp_fifo u_tx_fifo
   (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .flush_in(flush),
      .push_in(txf_push),
      .push_data_in(wdata_in[`USDP_DATA_MSB:0]),
      .pop_in(txf_pop),
      .head_out(txf_head),
      .empty_out(txf_empty),
      .full_out(txf_full)
   );

   //------------------------------------------------------------
   // Transmit handshake
   //------------------------------------------------------------
   assign tx_valid_out = st_ff.fifo_en ? !txf_empty : st_ff.tx_full;
   assign tx_data_out = st_ff.fifo_en ? txf_head : st_ff.tx_buf;
   assign tx_uart_sel_out = !st_ff.ir_mode;
   assign tx_ir_sel_n_out = !st_ff.ir_mode;
   assign tx_take = tx_valid_out && tx_ready_in;

   assign data_ready_flag_out = st_ff.fifo_en ? !rxf_empty : st_ff.rx_full;
   assign holding_empty_flag_out = st_ff.fifo_en ? txf_empty : !st_ff.tx_full;

   //------------------------------------------------------------
   // Events
   //------------------------------------------------------------
   assign rx_ovr_ev = rx_strobe_in && (st_ff.fifo_en ? rxf_full
      : (st_ff.rx_full && !data_rd));
   assign tx_lost_ev = data_wr && st_ff.fifo_en && txf_full;
   always_comb
   begin
      events = '0;
      events[`USDP_IRQ_RX_OVR] = rx_ovr_ev;
      events[`USDP_IRQ_TX_LOST] = tx_lost_ev;
      events[`USDP_IRQ_RX_DATA] = rx_strobe_in && !rx_ovr_ev;
   end

   assign irq_out = |(st_ff.irq_stat & st_ff.irq_mask);
   assign overrun_out = st_ff.overrun;
   assign rdata_out = st_ff.rdata;

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdata = '0;
      nxt_st.overrun = rx_ovr_ev;

      // Single receive buffer, overwritten if unread
      if (!st_ff.fifo_en)
      begin
         if (rx_strobe_in)
         begin
            nxt_st.rx_buf = rx_byte;
            nxt_st.rx_full = 1'b1;
         end
         else if (data_rd)
         begin
            nxt_st.rx_full = 1'b0;
         end
      end

      // Single transmit holding buffer
      if (!st_ff.fifo_en)
      begin
         if (data_wr)
         begin
            nxt_st.tx_buf = wdata_in[`USDP_DATA_MSB:0];
            nxt_st.tx_full = 1'b1;
         end
         else if (tx_take)
         begin
            nxt_st.tx_full = 1'b0;
         end
      end

      if (ctrl_wr)
      begin
         nxt_st.fifo_en = wdata_in[`USDP_CTRL_FIFO_EN];
         nxt_st.ir_mode = wdata_in[`USDP_CTRL_IR_MODE];
         if (flush)
         begin
            nxt_st.rx_full = 1'b0;
            nxt_st.tx_full = 1'b0;
         end
      end

      if (wr_in && hit(addr_in, `USDP_IRQ_MASK_ADDR))
      begin
         nxt_st.irq_mask = wdata_in[2:0];
      end

      // Write-one-to-clear; a same-cycle event wins
      if (wr_in && hit(addr_in, `USDP_IRQ_STAT_ADDR))
      begin
         nxt_st.irq_stat = st_ff.irq_stat & ~wdata_in[2:0];
      end
      nxt_st.irq_stat = nxt_st.irq_stat | events;

      // Read data, valid in the following cycle only
      if (rd_in)
      begin
         if (is_alias(addr_in))
         begin
            nxt_st.rdata[`USDP_DATA_MSB:0] = st_ff.fifo_en ? rxf_head
               : st_ff.rx_buf;
            // Upper bits stay zero
            nxt_st.rdata[15:8] = 8'h00;
         end
         else if (hit(addr_in, `USDP_CTRL_ADDR))
         begin
            nxt_st.rdata[`USDP_CTRL_FIFO_EN] = st_ff.fifo_en;
            nxt_st.rdata[`USDP_CTRL_IR_MODE] = st_ff.ir_mode;
         end
         else if (hit(addr_in, `USDP_STAT_ADDR))
         begin
            nxt_st.rdata[`USDP_STAT_DR] = data_ready_flag_out;
            nxt_st.rdata[`USDP_STAT_HOLDING_EMPTY_FLAG] = holding_empty_flag_out;
         end
         else if (hit(addr_in, `USDP_IRQ_STAT_ADDR))
         begin
            nxt_st.rdata[2:0] = st_ff.irq_stat;
         end
         else if (hit(addr_in, `USDP_IRQ_MASK_ADDR))
         begin
            nxt_st.rdata[2:0] = st_ff.irq_mask;
         end
      end
      nxt_st.tx_data = tx_data_out;
   end

   always_ff @(posedge mclk_in)
   begin
      if (reset_in)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end
endmodule // usdp_core

//--- testbench/usdp_props.sv
/*
 Checker on the usdp_core ports, bound to every usdp_core instance.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "usdp_params.svh"

module usdp_props
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // Register port
   input wire usdp_pkg::usdp_word_t addr_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire usdp_pkg::usdp_word_t rdata_out,
   // Serial side
   input wire logic rx_strobe_in,
   input wire logic tx_valid_out,
   input wire logic tx_ready_in,
   input wire usdp_pkg::usdp_byte_t tx_data_out,
   input wire logic tx_uart_sel_out,
   input wire logic tx_ir_sel_n_out,
   // Status
   input wire logic data_ready_flag_out,
   input wire logic holding_empty_flag_out,
   input wire logic overrun_out
);
   import usdp_pkg::*;
   logic hit;
   assign hit = addr_in >= `USDP_ALIAS_BASE && addr_in <= `USDP_ALIAS_BASE + 32'h3C;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
      else $error("read data not zero outside a read");
   a_rsvd_zero: assert property ($past(rd_in) |-> rdata_out[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   a_ovr_cause: assert property (overrun_out |-> $past(rx_strobe_in) && $past(data_ready_flag_out))
      else $error("overrun without an unread byte");
   a_dr_set: assert property (rx_strobe_in && !wr_in |=> data_ready_flag_out)
      else $error("data ready missing after receive");
   a_holding_empty_flag_clr: assert property (wr_in && hit && !tx_valid_out |=> !holding_empty_flag_out)
      else $error("holding empty not cleared by write");
   a_tx_hold: assert property (tx_valid_out && !tx_ready_in && !wr_in |=> tx_valid_out && $stable(tx_data_out))
      else $error("transmit byte not held while stalled");
   a_flag_pair: assert property (holding_empty_flag_out != tx_valid_out)
      else $error("holding empty disagrees with transmit valid");
   a_mode_sel: assert property (tx_uart_sel_out == tx_ir_sel_n_out)
      else $error("output selects disagree");
endmodule // usdp_props

bind usdp_core usdp_props props_u (.mclk_in, .reset_in, .addr_in, .wr_in, .rd_in, .rdata_out,
   .rx_strobe_in, .tx_valid_out, .tx_ready_in, .tx_data_out, .tx_uart_sel_out,
   .tx_ir_sel_n_out, .data_ready_flag_out, .holding_empty_flag_out, .overrun_out);

//--- testbench/usdp_engine_model.sv
/*
 Serial engine model: takes transmit bytes and records them in order.
 Assumes stall_in changes right after a rising clock edge.
*/
`timescale 1ns/10ps

module usdp_engine_model
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic reset_in,
   // Pacing
   input wire logic stall_in,
   // Transmit handshake
   input wire logic tx_valid_in,
   input wire usdp_pkg::usdp_byte_t tx_data_in,
   output logic tx_ready_out
);
   import usdp_pkg::*;
   usdp_byte_t got_q[$];
   assign tx_ready_out = !stall_in;
   always @(posedge mclk_in)
   begin
      if (reset_in)
         got_q = {};
      else if (tx_valid_in && tx_ready_out)
         got_q.push_back(tx_data_in);
   end
endmodule // usdp_engine_model

//--- testbench/tb_top.sv
/*
 Register-level testbench for usdp_core with a serial engine model.
 Assumes the register map of usdp_params.svh.
*/
`timescale 1ns/10ps
`include "usdp_params.svh"

module tb_top;
   import usdp_pkg::*;
   logic mclk = 0, rst = 1, wr = 0, rd = 0, rxs = 0, stall = 0;
   logic txv, txr, usel, isel_n, dr, he, ovr, irq, ovr_seen;
   usdp_word_t addr = 0, wdata = 0, rdata;
   usdp_byte_t rxu = 0, rxi = 0, txd;
   int err_total = 0, n_compared = 0, cyc = 0, i;

   usdp_core dut_u (.mclk_in(mclk), .reset_in(rst), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rx_strobe_in(rxs), .rx_uart_data_in(rxu),
      .rx_ir_data_in(rxi), .tx_valid_out(txv), .tx_ready_in(txr), .tx_data_out(txd),
      .tx_uart_sel_out(usel), .tx_ir_sel_n_out(isel_n), .data_ready_flag_out(dr),
      .holding_empty_flag_out(he), .overrun_out(ovr), .irq_out(irq));
   usdp_engine_model model_u (.mclk_in(mclk), .reset_in(rst), .stall_in(stall),
      .tx_valid_in(txv), .tx_data_in(txd), .tx_ready_out(txr));

   always #50 mclk = ~mclk;

   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(string nm, usdp_word_t e, usdp_word_t g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr_reg(usdp_word_t a, usdp_word_t d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(usdp_word_t a, usdp_word_t e, string nm);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(nm, e, rdata);
   endtask

   task automatic rx(usdp_byte_t u, usdp_byte_t r);
      @(posedge mclk);
      rxu <= u;
      rxi <= r;
      rxs <= 1'b1;
      @(posedge mclk);
      rxs <= 1'b0;
      #1 ovr_seen = ovr;
   endtask

   initial
   begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(`USDP_ALIAS_TWO, 32'h0, "data_reset");
      rd_chk(`USDP_STAT_ADDR, 32'h20, "stat_reset");
      rd_chk(32'h5000_1070, 32'h0, "unmapped");
      $display("test reset done");
      for (i = 0; i < 16; i++)
      begin
         rx(8'h5A ^ 8'(i), 8'h0);
         rd_chk(`USDP_ALIAS_BASE + 32'(4 * i), 32'h5A ^ 32'(i), "alias");
      end
      wr_reg(`USDP_CTRL_ADDR, 32'h2);
      chk("ir_sel", 0, isel_n);
      chk("uart_sel_ir", 0, usel);
      rx(8'h11, 8'hC3);
      rd_chk(`USDP_ALIAS_TWO, 32'hC3, "ir_rx");
      wr_reg(`USDP_CTRL_ADDR, 32'h0);
      chk("uart_sel", 1, usel);
      $display("test alias done");
      rx(8'h21, 8'h0);
      rx(8'h22, 8'h0);
      chk("ovr_off", 1, ovr_seen);
      chk("irq_masked", 0, irq);
      wr_reg(`USDP_IRQ_MASK_ADDR, 32'h1);
      chk("irq_on", 1, irq);
      rd_chk(`USDP_IRQ_STAT_ADDR, 32'h5, "irq_stat");
      wr_reg(`USDP_IRQ_STAT_ADDR, 32'h1);
      chk("irq_clr", 0, irq);
      rd_chk(`USDP_ALIAS_TWO, 32'h22, "ovr_data");
      chk("dr_off", 0, dr);
      $display("test overrun done");
      wr_reg(`USDP_CTRL_ADDR, 32'h1);
      for (i = 0; i < 17; i++)
      begin
         rx(8'h40 + 8'(i), 8'h0);
         chk("ovr_fill", i == 16, ovr_seen);
      end
      for (i = 0; i < 16; i++)
         rd_chk(`USDP_ALIAS_TWO, 32'h40 + 32'(i), "rx_fifo");
      chk("dr_empty", 0, dr);
      $display("test rx fifo done");
      wr_reg(`USDP_CTRL_ADDR, 32'h0);
      @(posedge mclk) stall <= 1'b1;
      wr_reg(`USDP_ALIAS_TWO, 32'hFF41);
      chk("holding_empty_flag_clr", 0, he);
      wr_reg(`USDP_ALIAS_TWO, 32'h42);
      chk("tx_data", 32'h42, txd);
      @(posedge mclk) stall <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk("tx_count", 1, model_u.got_q.size());
      chk("tx_byte", 32'h42, model_u.got_q[0]);
      chk("holding_empty_flag_set", 1, he);
      $display("test tx holding done");
      wr_reg(`USDP_CTRL_ADDR, 32'h1);
      @(posedge mclk) stall <= 1'b1;
      for (i = 0; i < 17; i++)
         wr_reg(`USDP_ALIAS_BASE + 32'(4 * (i % 16)), 32'h60 + 32'(i));
      rd_chk(`USDP_IRQ_STAT_ADDR, 32'h7, "irq_lost");
      @(posedge mclk) stall <= 1'b0;
      repeat (20) @(posedge mclk);
      #1 chk("tx_total", 17, model_u.got_q.size());
      for (i = 0; i < 16; i++)
         chk("tx_fifo", 32'h60 + 32'(i), model_u.got_q[i + 1]);
      $display("test tx fifo done");
      finish_test();
   end
endmodule // tb_top
